// ### pkg/rtc16_map.svh
`ifndef RTC16_MAP_SVH
`define RTC16_MAP_SVH
// What this block does
// - Divide select: off, or 1..1024
// - Tick count advances per prescaled edge
// - Compare match flags on following count
// - Overflow after wrap value, count returns zero
// - Events every third/second occurrence for small wrap
// - Sync pending while writes cross domains
// - Written count takes effect after two reference edges
// - Match level nonzero enables match request
// - Wrap level nonzero enables wrap request
// - Match flag set on count, cleared
// - Wrap flag set on count, cleared
// - Low write latches, low read captures high
// - Any reference source accepted on input
// - Keeps counting asleep, can wake device
// - Count low byte at 0x08, resets zero
// - Wrap value resets all ones, is top
// - Compare above wrap never matches
`define RTC16_IDX_CTRL     4'h0
`define RTC16_IDX_STATUS   4'h1
`define RTC16_IDX_IRQ_LEVEL_CONTROL  4'h2
`define RTC16_IDX_FLAGS    4'h3
`define RTC16_IDX_TEMP     4'h4
`define RTC16_IDX_CNTLO    4'h8
`define RTC16_IDX_CNTHI    4'h9
`define RTC16_IDX_WRAPLO   4'hA
`define RTC16_IDX_WRAPHI   4'hB
`define RTC16_IDX_CMPLO    4'hC
`define RTC16_IDX_CMPHI    4'hD
`define RTC16_WRAP_RST     16'hFFFF
`define RTC16_CMP_RST      16'h0000
`define RTC16_CNT_RST      16'h0000
`define RTC16_SYNC_EDGES   2'h2
`define RTC16_WRAP_BIT     0
`define RTC16_MATCH_BIT    1
`define RTC16_RESP_OKAY    2'h0
`define RTC16_RESP_SLVERR  2'h2
`endif

// ### pkg/rtc16_pkg.sv
package rtc16_pkg;
	typedef enum logic [2:0] {
		RTC16_DIV_OFF  = 3'h0,
		RTC16_DIV_1    = 3'h1,
		RTC16_DIV_2    = 3'h2,
		RTC16_DIV_8    = 3'h3,
		RTC16_DIV_16   = 3'h4,
		RTC16_DIV_64   = 3'h5,
		RTC16_DIV_256  = 3'h6,
		RTC16_DIV_MAX  = 3'h7
	} rtc16_div_t;
	typedef logic [3:0] rtc16_idx_t;
endpackage : rtc16_pkg

// ### pkg/rtc16_regbus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rtc16_regbus_if;
	import rtc16_pkg::*;
	logic       wr_stb;
	rtc16_idx_t wr_idx;
	logic [7:0] wr_data;
	logic       wr_err;
	logic       rd_stb;
	rtc16_idx_t rd_idx;
	logic [7:0] rd_data;
	logic       rd_err;
	modport master (output wr_stb, wr_idx, wr_data, rd_stb, rd_idx,
		input wr_err, rd_data, rd_err);
	modport regs (input wr_stb, wr_idx, wr_data, rd_stb, rd_idx,
		output wr_err, rd_data, rd_err);
endinterface : rtc16_regbus_if
`default_nettype wire

// ### hw/rtc16_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module rtc16_prescaler (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// Reference edge in, prescaled edge out
	input  wire logic              ref_tick,
	input  wire rtc16_pkg::rtc16_div_t div_sel,
	output logic                   cnt_tick
);
	import rtc16_pkg::*;

	logic [9:0] pre_reg;

	function automatic logic [9:0] div_mask(input rtc16_div_t s);
		unique case (s)
			RTC16_DIV_OFF: div_mask = 10'h000;
			RTC16_DIV_1:   div_mask = 10'h000;
			RTC16_DIV_2:   div_mask = 10'h001;
			RTC16_DIV_8:   div_mask = 10'h007;
			RTC16_DIV_16:  div_mask = 10'h00F;
			RTC16_DIV_64:  div_mask = 10'h03F;
			RTC16_DIV_256: div_mask = 10'h0FF;
			RTC16_DIV_MAX: div_mask = 10'h3FF;
		endcase
	endfunction : div_mask

	// Held at zero while stopped so a restart begins a full period
	always_ff @(posedge sys_clk) begin
		if (!resetn || div_sel == RTC16_DIV_OFF) begin
			pre_reg <= 10'h000;
		end else if (ref_tick) begin
			pre_reg <= pre_reg + 10'h001;
		end
	end

	always_comb begin
		cnt_tick = ref_tick && div_sel != RTC16_DIV_OFF &&
			(pre_reg & div_mask(div_sel)) == div_mask(div_sel);
	end
endmodule : rtc16_prescaler
`default_nettype wire

// ### hw/rtc16_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc16_map.svh"
module rtc16_axil_slave #(
	parameter int ADDR_W = 6
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// Write address and data
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// Read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Register side
	rtc16_regbus_if.master         bus
);
	import rtc16_pkg::*;

	logic aw_held, w_held, ar_held, wr_bad, rd_bad, w_lane_reg, wr_skip;

	// A write without the low lane still answers and frees both channels
	assign wr_skip = aw_held && w_held && !w_lane_reg && !bus.wr_stb && !bvalid;

	// Only the low byte lane carries register data
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			awready <= 1'b0;
			wr_bad <= 1'b0;
			bus.wr_idx <= 4'h0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			awready <= 1'b0;
			bus.wr_idx <= awaddr[5:2];
			wr_bad <= (awaddr >> 6) != '0;
		end else if (bus.wr_stb || wr_skip) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !bvalid) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			w_held <= 1'b0;
			wready <= 1'b0;
			bus.wr_data <= 8'h00;
			w_lane_reg <= 1'b0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			wready <= 1'b0;
			bus.wr_data <= wdata[7:0];
			w_lane_reg <= wstrb[0];
		end else if (bus.wr_stb || wr_skip) begin
			w_held <= 1'b0;
		end else if (!w_held && !bvalid) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bus.wr_stb <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RTC16_RESP_OKAY;
		end else begin
			bus.wr_stb <= aw_held && w_held && !bus.wr_stb && !bvalid &&
				w_lane_reg;
			if (bus.wr_stb) begin
				bvalid <= 1'b1;
				bresp <= (bus.wr_err || wr_bad) ? `RTC16_RESP_SLVERR
					: `RTC16_RESP_OKAY;
			end else if (wr_skip) begin
				bvalid <= 1'b1;
				bresp <= `RTC16_RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ar_held <= 1'b0;
			arready <= 1'b0;
			rd_bad <= 1'b0;
			bus.rd_idx <= 4'h0;
		end else if (arvalid && arready) begin
			ar_held <= 1'b1;
			arready <= 1'b0;
			bus.rd_idx <= araddr[5:2];
			rd_bad <= (araddr >> 6) != '0;
		end else if (bus.rd_stb) begin
			ar_held <= 1'b0;
		end else if (!ar_held && !rvalid) begin
			arready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bus.rd_stb <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RTC16_RESP_OKAY;
		end else begin
			bus.rd_stb <= ar_held && !bus.rd_stb && !rvalid;
			if (bus.rd_stb) begin
				rvalid <= 1'b1;
				rdata <= {24'h000000, bus.rd_data};
				rresp <= (bus.rd_err || rd_bad) ? `RTC16_RESP_SLVERR
					: `RTC16_RESP_OKAY;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule : rtc16_axil_slave
`default_nettype wire

// ### hw/rtc16_counter_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc16_map.svh"
module rtc16_counter_core #(
	parameter int ADDR_W = 6
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Reference clock pin and power manager
	input  wire logic              ref_clk_in,
	input  wire logic              wake_resync,
	// Interrupt controller
	input  wire logic              wrap_vector_ack,
	input  wire logic              match_vector_ack,
	output logic                   wrap_irq_req,
	output logic [1:0]             wrap_irq_level,
	output logic                   match_irq_req,
	output logic [1:0]             match_irq_level,
	output logic                   wake_request,
	// Event system
	output logic                   wrap_event,
	output logic                   match_event
);
	import rtc16_pkg::*;

	rtc16_regbus_if bus ();

	logic [2:0]  ref_sync;
	logic        ref_lvl_reg;
	logic        ref_tick;
	logic        cnt_tick;
	rtc16_div_t  ctrl_sh_reg, ctrl_act_reg;
	logic [15:0] wrap_sh_reg, wrap_act_reg;
	logic [15:0] cmp_sh_reg, cmp_act_reg;
	logic [15:0] cnt_sh_reg, tick_count_reg;
	logic [7:0]  temp_reg;
	logic [3:0]  lvl_reg;
	logic        wrap_flag_reg, match_flag_reg;
	logic        sync_pending_flag_reg, pend_cnt_reg;
	logic [1:0]  pend_edges_reg;
	logic        sync_done, wr_any_sync, cnt_commit;
	logic        wrap_hit, match_hit;
	logic [1:0]  wrap_occ_reg, match_occ_reg;
	logic        wr_ctrl, wr_wrap, wr_cmp;

	// Occurrences per event when the wrap value is very small
	function automatic logic [1:0] ev_div(input logic [15:0] w);
		ev_div = (w == 16'h0000) ? 2'h3 : (w == 16'h0001) ? 2'h2 : 2'h1;
	endfunction : ev_div

	function automatic logic is_wr(input rtc16_idx_t i);
		is_wr = bus.wr_stb && bus.wr_idx == i;
	endfunction : is_wr

	rtc16_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_slave (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.bus     (bus.master)
	);

	// Any reference source arrives as a level on one pin
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ref_sync <= 3'h0;
			ref_lvl_reg <= 1'b0;
		end else begin
			ref_sync <= {ref_sync[1:0], ref_clk_in};
			if (ref_sync[1] == ref_sync[2]) begin
				ref_lvl_reg <= ref_sync[2];
			end
		end
	end

	assign ref_tick = ref_sync[1] && ref_sync[2] && !ref_lvl_reg;

	rtc16_prescaler u_pre (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.ref_tick (ref_tick),
		.div_sel  (ctrl_act_reg),
		.cnt_tick (cnt_tick)
	);

	// Process form, so the bus signals read inside the function wake it
	always_comb begin
		wr_ctrl = is_wr(`RTC16_IDX_CTRL);
		wr_wrap = is_wr(`RTC16_IDX_WRAPHI);
		wr_cmp = is_wr(`RTC16_IDX_CMPHI);
		cnt_commit = is_wr(`RTC16_IDX_CNTHI);
	end
	assign wr_any_sync = wr_ctrl || wr_wrap || wr_cmp || cnt_commit;
	assign sync_done = sync_pending_flag_reg && ref_tick &&
		pend_edges_reg == `RTC16_SYNC_EDGES - 2'h1;

	// Software-side copies; a high byte write commits the word
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl_sh_reg <= RTC16_DIV_OFF;
			wrap_sh_reg <= `RTC16_WRAP_RST;
			cmp_sh_reg <= `RTC16_CMP_RST;
			cnt_sh_reg <= `RTC16_CNT_RST;
			lvl_reg <= 4'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_sh_reg <= rtc16_div_t'(bus.wr_data[2:0]);
			end
			if (wr_wrap) begin
				wrap_sh_reg <= {bus.wr_data, temp_reg};
			end
			if (wr_cmp) begin
				cmp_sh_reg <= {bus.wr_data, temp_reg};
			end
			if (cnt_commit) begin
				cnt_sh_reg <= {bus.wr_data, temp_reg};
			end
			if (is_wr(`RTC16_IDX_IRQ_LEVEL_CONTROL)) begin
				lvl_reg <= bus.wr_data[3:0];
			end
		end
	end

	// Byte hold latch for 16-bit access
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			temp_reg <= 8'h00;
		end else if (bus.wr_stb && (bus.wr_idx == `RTC16_IDX_TEMP ||
			bus.wr_idx == `RTC16_IDX_CNTLO || bus.wr_idx == `RTC16_IDX_WRAPLO ||
			bus.wr_idx == `RTC16_IDX_CMPLO)) begin
			temp_reg <= bus.wr_data;
		end else if (bus.rd_stb) begin
			unique case (bus.rd_idx)
				`RTC16_IDX_CNTLO:  temp_reg <= tick_count_reg[15:8];
				`RTC16_IDX_WRAPLO: temp_reg <= wrap_sh_reg[15:8];
				`RTC16_IDX_CMPLO:  temp_reg <= cmp_sh_reg[15:8];
				default:           temp_reg <= temp_reg;
			endcase
		end
	end

	// A new write restarts the crossing, so set wins over completion
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sync_pending_flag_reg <= 1'b0;
			pend_edges_reg <= 2'h0;
			pend_cnt_reg <= 1'b0;
		end else begin
			if (wr_any_sync || wake_resync) begin
				sync_pending_flag_reg <= 1'b1;
				pend_edges_reg <= 2'h0;
			end else if (sync_done) begin
				sync_pending_flag_reg <= 1'b0;
				pend_edges_reg <= 2'h0;
			end else if (sync_pending_flag_reg && ref_tick) begin
				pend_edges_reg <= pend_edges_reg + 2'h1;
			end
			pend_cnt_reg <= (pend_cnt_reg && !sync_done) || cnt_commit;
		end
	end

	// Counter side copies only change on a completed crossing
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl_act_reg <= RTC16_DIV_OFF;
			wrap_act_reg <= `RTC16_WRAP_RST;
			cmp_act_reg <= `RTC16_CMP_RST;
		end else if (sync_done) begin
			ctrl_act_reg <= ctrl_sh_reg;
			wrap_act_reg <= wrap_sh_reg;
			cmp_act_reg <= cmp_sh_reg;
		end
	end

	assign wrap_hit = cnt_tick && tick_count_reg == wrap_act_reg;
	assign match_hit = cnt_tick && tick_count_reg == cmp_act_reg &&
		cmp_act_reg <= wrap_act_reg;

	// Keeps running through sleep: only the reference edge drives it
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tick_count_reg <= `RTC16_CNT_RST;
		end else if (sync_done && pend_cnt_reg) begin
			tick_count_reg <= cnt_sh_reg;
		end else if (wrap_hit) begin
			tick_count_reg <= 16'h0000;
		end else if (cnt_tick) begin
			tick_count_reg <= tick_count_reg + 16'h0001;
		end
	end

	// Flags: a hit in the clearing cycle keeps the flag set
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wrap_flag_reg <= 1'b0;
			match_flag_reg <= 1'b0;
		end else begin
			if (wrap_hit) begin
				wrap_flag_reg <= 1'b1;
			end else if (wrap_vector_ack || (is_wr(`RTC16_IDX_FLAGS) &&
				bus.wr_data[`RTC16_WRAP_BIT])) begin
				wrap_flag_reg <= 1'b0;
			end
			if (match_hit) begin
				match_flag_reg <= 1'b1;
			end else if (match_vector_ack || (is_wr(`RTC16_IDX_FLAGS) &&
				bus.wr_data[`RTC16_MATCH_BIT])) begin
				match_flag_reg <= 1'b0;
			end
		end
	end

	// Events thin out when the wrap value is below two
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wrap_occ_reg <= 2'h0;
			match_occ_reg <= 2'h0;
			wrap_event <= 1'b0;
			match_event <= 1'b0;
		end else begin
			wrap_event <= 1'b0;
			match_event <= 1'b0;
			if (wrap_hit) begin
				if (wrap_occ_reg + 2'h1 >= ev_div(wrap_act_reg)) begin
					wrap_event <= 1'b1;
					wrap_occ_reg <= 2'h0;
				end else begin
					wrap_occ_reg <= wrap_occ_reg + 2'h1;
				end
			end
			if (match_hit) begin
				if (match_occ_reg + 2'h1 >= ev_div(wrap_act_reg)) begin
					match_event <= 1'b1;
					match_occ_reg <= 2'h0;
				end else begin
					match_occ_reg <= match_occ_reg + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wrap_irq_req <= 1'b0;
			match_irq_req <= 1'b0;
			wrap_irq_level <= 2'h0;
			match_irq_level <= 2'h0;
			wake_request <= 1'b0;
		end else begin
			wrap_irq_req <= wrap_flag_reg && lvl_reg[1:0] != 2'h0;
			match_irq_req <= match_flag_reg && lvl_reg[3:2] != 2'h0;
			wrap_irq_level <= lvl_reg[1:0];
			match_irq_level <= lvl_reg[3:2];
			wake_request <= (wrap_flag_reg && lvl_reg[1:0] != 2'h0) ||
				(match_flag_reg && lvl_reg[3:2] != 2'h0);
		end
	end

	// Read mux; holes in the map answer with a slave error
	always_comb begin
		bus.rd_err = 1'b0;
		unique case (bus.rd_idx)
			`RTC16_IDX_CTRL:    bus.rd_data = {5'h00, ctrl_sh_reg};
			`RTC16_IDX_STATUS:  bus.rd_data = {7'h00, sync_pending_flag_reg};
			`RTC16_IDX_IRQ_LEVEL_CONTROL: bus.rd_data = {4'h0, lvl_reg};
			`RTC16_IDX_FLAGS:   bus.rd_data = {6'h00, match_flag_reg,
				wrap_flag_reg};
			`RTC16_IDX_TEMP:    bus.rd_data = temp_reg;
			`RTC16_IDX_CNTLO:   bus.rd_data = tick_count_reg[7:0];
			`RTC16_IDX_WRAPLO:  bus.rd_data = wrap_sh_reg[7:0];
			`RTC16_IDX_CMPLO:   bus.rd_data = cmp_sh_reg[7:0];
			`RTC16_IDX_CNTHI, `RTC16_IDX_WRAPHI, `RTC16_IDX_CMPHI:
				bus.rd_data = temp_reg;
			default: begin
				bus.rd_data = 8'h00;
				bus.rd_err = 1'b1;
			end
		endcase
	end

	always_comb begin
		unique case (bus.wr_idx)
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: bus.wr_err = 1'b1;
			`RTC16_IDX_STATUS:            bus.wr_err = 1'b0;
			default:                      bus.wr_err = 1'b0;
		endcase
	end

	sequence s_cnt_commit;
		cnt_commit ##1 sync_pending_flag_reg;
	endsequence

	sequence s_wrap_step;
		wrap_hit && !(sync_done && pend_cnt_reg);
	endsequence

	a_stop_when_off: assert property (@(posedge sys_clk) disable iff (!resetn)
		ctrl_act_reg == RTC16_DIV_OFF |-> !cnt_tick)
		else $error("counter ticked while stopped");

	a_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
		cnt_tick && !wrap_hit && !(sync_done && pend_cnt_reg) |=>
		tick_count_reg == $past(tick_count_reg) + 16'h0001)
		else $error("count did not advance by one");

	a_wrap_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_wrap_step |=> tick_count_reg == 16'h0000 && wrap_flag_reg)
		else $error("wrap did not clear count and set flag");

	a_match_flag_set: assert property (@(posedge sys_clk) disable iff (!resetn)
		cnt_tick && tick_count_reg == cmp_act_reg && cmp_act_reg <= wrap_act_reg
		|=> match_flag_reg)
		else $error("match flag not set after compare");

	a_no_match_above: assert property (@(posedge sys_clk) disable iff (!resetn)
		cmp_act_reg > wrap_act_reg |-> !match_hit ##1 !match_event)
		else $error("match beyond wrap value");

	a_event_every: assert property (@(posedge sys_clk) disable iff (!resetn)
		wrap_hit && wrap_act_reg >= 16'h0002 |=> wrap_event)
		else $error("missing wrap event");

	a_sync_busy_set: assert property (@(posedge sys_clk) disable iff (!resetn)
		cnt_commit |-> s_cnt_commit)
		else $error("pending flag not raised by write");

	a_count_applies: assert property (@(posedge sys_clk) disable iff (!resetn)
		sync_done && pend_cnt_reg |=> tick_count_reg == $past(cnt_sh_reg)
		&& !sync_pending_flag_reg || $past(wr_any_sync || wake_resync))
		else $error("written count not applied");

	a_wrap_irq_req: assert property (@(posedge sys_clk) disable iff (!resetn)
		wrap_flag_reg && lvl_reg[1:0] != 2'h0 |=> wrap_irq_req)
		else $error("wrap request missing");

	a_match_irq_req: assert property (@(posedge sys_clk) disable iff (!resetn)
		!match_flag_reg |=> !match_irq_req)
		else $error("match request without flag");

	a_temp_capture: assert property (@(posedge sys_clk) disable iff (!resetn)
		bus.rd_stb && bus.rd_idx == `RTC16_IDX_CNTLO && !bus.wr_stb
		|=> temp_reg == $past(tick_count_reg[15:8]))
		else $error("high byte not captured");
endmodule : rtc16_counter_core
`default_nettype wire

// ### sim/tb_rtc16_counter_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rtc16_counter_core;
	import rtc16_pkg::*;
	// Bus and block signals
	logic        sys_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        ref_clk_in, wake_resync, wrap_vector_ack, match_vector_ack;
	logic        wrap_irq_req, match_irq_req, wake_request, wrap_event, match_event;
	logic [5:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, keep;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, wrap_irq_level, match_irq_level, r;
	int          fail_count, comparisons;

	rtc16_counter_core #(.ADDR_W(6)) DUT (
		.sys_clk(sys_clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ref_clk_in(ref_clk_in),
		.wake_resync(wake_resync), .wrap_vector_ack(wrap_vector_ack),
		.match_vector_ack(match_vector_ack), .wrap_irq_req(wrap_irq_req),
		.wrap_irq_level(wrap_irq_level), .match_irq_req(match_irq_req),
		.match_irq_level(match_irq_level), .wake_request(wake_request),
		.wrap_event(wrap_event), .match_event(match_event)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Reference runs at one eighth of the system clock to keep long divides affordable
	initial begin
		ref_clk_in = 1'b0;
		forever begin
			repeat (4) @(posedge sys_clk);
			ref_clk_in <= ~ref_clk_in;
		end
	end

	task automatic close_out;
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (90000) @(posedge sys_clk);
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		close_out();
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Address and data offered together; each released once taken
	task automatic axi_wr(input logic [3:0] idx, input logic [7:0] dat);
		@(posedge sys_clk);
		awaddr <= {idx, 2'h0};
		awvalid <= 1'b1;
		wdata <= {24'h0, dat};
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] idx);
		@(posedge sys_clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Software side never touches synced registers while a crossing is open
	task automatic wait_sync;
		do axi_rd(4'h1); while (rd[0] !== 1'b0);
	endtask : wait_sync

	task automatic set16(input logic [3:0] lo, input logic [15:0] v);
		axi_wr(lo, v[7:0]);
		axi_wr(lo + 4'h1, v[15:8]);
		wait_sync();
	endtask : set16

	// Counter stopped and cleared first so a smaller top cannot strand it above
	task automatic setup(input logic [7:0] dv, input logic [15:0] top);
		axi_wr(4'h0, 8'h00);
		wait_sync();
		set16(4'h8, 16'h0000);
		set16(4'hA, top);
		axi_wr(4'h0, dv);
		wait_sync();
	endtask : setup

	task automatic t_reset;
		logic [3:0] ix [7];
		logic [7:0] ev [7];
		ix = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hA, 4'hB};
		ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
		foreach (ix[i]) begin
			axi_rd(ix[i]);
			chk(rd, {24'h0, ev[i]});
		end
		axi_rd(4'h4);
		chk(rd, 32'h0000_00FF);
		axi_rd(4'h5);
		chk({30'h0, r}, 32'h2);
		axi_wr(4'h7, 8'h11);
		chk({30'h0, r}, 32'h2);
		axi_wr(4'hC, 8'h5A);
		chk({30'h0, r}, 32'h0);
		axi_rd(4'h4);
		chk(rd, 32'h0000_005A);
	endtask : t_reset

	task automatic t_sync;
		axi_wr(4'h9, 8'h00);
		axi_rd(4'h1);
		chk(rd, 32'h1);
		wait_sync();
		@(posedge sys_clk);
		wake_resync <= 1'b1;
		@(posedge sys_clk);
		wake_resync <= 1'b0;
		axi_rd(4'h1);
		chk(rd, 32'h1);
		wait_sync();
	endtask : t_sync

	// Spacing of overflow events for divide codes 1 to 7 and the small tops
	task automatic t_events;
		int dv [9];
		int tp [9];
		int gp [9];
		int n;
		dv = '{1, 2, 3, 4, 5, 6, 7, 1, 1};
		tp = '{2, 2, 2, 2, 2, 2, 2, 0, 1};
		gp = '{24, 48, 192, 384, 1536, 6144, 24576, 24, 32};
		foreach (dv[i]) begin
			setup(8'(dv[i]), 16'(tp[i]));
			do @(posedge sys_clk); while (!wrap_event);
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (!wrap_event);
			chk(32'(n), 32'(gp[i]));
		end
	endtask : t_events

	task automatic t_flags;
		int n;
		setup(8'h01, 16'h0009);
		set16(4'hC, 16'h0004);
		axi_wr(4'h2, 8'h06);
		axi_wr(4'h3, 8'h03);
		do @(posedge sys_clk); while (!match_event);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!match_event);
		chk(32'(n), 32'h0000_0050);
		do @(posedge sys_clk); while (!match_irq_req);
		chk({30'h0, match_irq_level}, 32'h1);
		chk({31'h0, wake_request}, 32'h1);
		axi_rd(4'h3);
		chk({31'h0, rd[1]}, 32'h1);
		@(posedge sys_clk);
		match_vector_ack <= 1'b1;
		@(posedge sys_clk);
		match_vector_ack <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({31'h0, match_irq_req}, 32'h0);
		do @(posedge sys_clk); while (!wrap_irq_req);
		chk({30'h0, wrap_irq_level}, 32'h2);
		axi_wr(4'h3, 8'h01);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, wrap_irq_req}, 32'h0);
		do @(posedge sys_clk); while (!wrap_irq_req);
		wrap_vector_ack <= 1'b1;
		@(posedge sys_clk);
		wrap_vector_ack <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({31'h0, wrap_irq_req}, 32'h0);
		set16(4'hC, 16'h0020);
		axi_wr(4'h3, 8'h03);
		repeat (300) @(posedge sys_clk);
		axi_rd(4'h3);
		chk({31'h0, rd[1]}, 32'h0);
		axi_wr(4'h0, 8'h00);
		wait_sync();
		axi_rd(4'h8);
		keep = rd;
		repeat (100) @(posedge sys_clk);
		axi_rd(4'h8);
		chk(rd, keep);
		set16(4'h8, 16'h1234);
		axi_rd(4'h8);
		chk(rd, 32'h0000_0034);
		axi_rd(4'h9);
		chk(rd, 32'h0000_0012);
	endtask : t_flags

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{wake_resync, wrap_vector_ack, match_vector_ack} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		fail_count = 0;
		comparisons = 0;
		resetn = 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_sync();
		t_events();
		t_flags();
		close_out();
	end
endmodule : tb_rtc16_counter_core
`default_nettype wire
